// File: inc/abs_pkg.sv
package abs_pkg;

    // Serial frame layout
    localparam int   ABS_DATA_BITS      = 8;    // Data bits per frame, LSB first
    localparam int   ABS_STOP_BITS_STD  = 1;    // Stop bits at ordinary rates
    localparam int   ABS_STOP_BITS_TTY  = 2;    // Stop bits at teletypewriter rate
    localparam logic ABS_LINE_IDLE      = 1'b1; // Level of the line between frames

    // Rate detection on a space character
    localparam int   ABS_SPACE_LOW_BITS = 6;    // Start bit plus five zero data bits
    localparam int   ABS_SKIP_BITS      = 3;    // Bits after the low run before stop
    localparam int   ABS_MIN_FULL       = 2;    // Shortest usable bit period, cycles

    // Sizes
    localparam int   ABS_CNT_W          = 20;   // Width of bit period counters
    localparam int   ABS_FIFO_DEPTH     = 8;    // Words in the receive FIFO

    // Rate detection states
    typedef enum logic [2:0] {
        ABS_RD_ARM  = 3'h0,
        ABS_RD_WAIT = 3'h1,
        ABS_RD_MEAS = 3'h2,
        ABS_RD_SKIP = 3'h3,
        ABS_RD_LOCK = 3'h4
    } abs_rd_t;

    // Transmitter states
    typedef enum logic [1:0] {
        ABS_TX_IDLE  = 2'h0,
        ABS_TX_START = 2'h1,
        ABS_TX_DATA  = 2'h2,
        ABS_TX_STOP  = 2'h3
    } abs_tx_t;

    // Receiver states
    typedef enum logic [1:0] {
        ABS_RX_IDLE = 2'h0,
        ABS_RX_DATA = 2'h1,
        ABS_RX_STOP = 2'h2
    } abs_rx_t;

endpackage : abs_pkg

// File: hw/abs_fifo.sv
`timescale 1ns/100ps
module abs_fifo #(
    parameter int WIDTH = 8,                  // Word width
    parameter int DEPTH = 8                   // Words of storage, a power of two
) (
    input  logic             clock_in,        // System clock
    input  logic             rst_n_in,        // Synchronous reset, active low
    input  logic             clk_en_in,       // Clock enable, freezes state when low
    input  logic [WIDTH-1:0] wr_data_in,      // Word to store
    input  logic             wr_valid_in,     // Word offered
    output logic             wr_ready_out,    // Room for a word
    output logic [WIDTH-1:0] rd_data_out,     // Oldest word, registered
    output logic             rd_valid_out,    // Oldest word present, registered
    input  logic             rd_ready_in      // Drain side takes the word
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            out_data;
        logic                        out_valid;
    } abs_fifo_st_t;

    abs_fifo_st_t st_r;
    abs_fifo_st_t st_nxt;
    logic         push;
    logic         load;

    // Handshakes on both sides
    assign wr_ready_out = (st_r.count != (AW+1)'(DEPTH));
    assign push         = wr_valid_in && wr_ready_out;
    assign load         = (!st_r.out_valid || rd_ready_in) && (st_r.count != '0);
    assign rd_data_out  = st_r.out_data;
    assign rd_valid_out = st_r.out_valid;

    // Store, move the oldest word to the output register, track fill
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr_ptr] = wr_data_in;
            st_nxt.wr_ptr           = st_r.wr_ptr + 1'b1;
        end
        if (load) begin
            st_nxt.out_data  = st_r.mem[st_r.rd_ptr];
            st_nxt.out_valid = 1'b1;
            st_nxt.rd_ptr    = st_r.rd_ptr + 1'b1;
        end else if (rd_ready_in) begin
            st_nxt.out_valid = 1'b0;
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(load);
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

endmodule : abs_fifo

// File: hw/abs_serial_console.sv
`timescale 1ns/100ps

// Behaviour
// R1: Every byte takes ten or eleven consecutive bit periods on the line.
// R2: Zero start bit, eight data bits LSB first, stop bits at one.
// R3: Two stop bits select the eleven-bit teletypewriter frame; otherwise one.
// R4: Output line rests at one between frames.
// R5: Receiver samples each bit once, at its middle; the code does not sample the start bit.
// R6: Sampled data bits are shifted into a byte equal to the sent byte.
// R7: Receive sampling is re-timed from each start bit falling edge.
// R8: All bits of a frame last the same stored period.
// R9: After reset or rate change, wait for a space character.
// R10: The terminal must send a space; other characters give wrong timing.
// R11: On the space, store a full bit period and a half bit period.
// R12: Transmitter times every bit with the stored full bit period.
// R13: Receiver uses both periods and presents the assembled byte.
// R14: Transmit and receive run at the rate of the measured space.
// R15: Rate is measured in system clocks, so clock frequency does not matter.
// R16: Handles rates from below 110 to beyond 9600 baud.
// R17: Rate detection may be re-run at any time to follow drift.
// R18: First data sample comes one and a half periods after the start edge.
// R19: Measure the six-bit low run of the space and divide by six.
// R20: Busy from frame start to last stop bit; requests meanwhile are ignored.
module abs_serial_console #(
    parameter int CNT_W = abs_pkg::ABS_CNT_W,        // Bit period counter width
    parameter int DEPTH = abs_pkg::ABS_FIFO_DEPTH    // Receive FIFO words
) (
    input  logic       clock_in,              // System clock, 40 MHz
    input  logic       rst_n_in,              // Synchronous reset, active low
    input  logic       clk_en_in,             // Clock enable, freezes state when low
    input  logic       serial_in_line_in,     // Serial input line from terminal
    output logic       serial_out_line_out,   // Serial output line to terminal
    input  logic       rate_detect_req_in,    // Pulse: measure the rate again
    output logic       rate_locked_out,       // Bit periods are measured
    input  logic       two_stop_in,           // Send two stop bits (110 baud)
    input  logic [7:0] tx_data_in,            // Byte to send
    input  logic       tx_valid_in,           // Byte to send is offered
    output logic       tx_ready_out,          // Transmitter takes a byte
    output logic       tx_busy_out,           // Frame on the output line
    output logic [7:0] rx_data_out,           // Received byte, head of FIFO
    output logic       rx_valid_out,          // Received byte present
    input  logic       rx_ready_in,           // Reader takes the received byte
    output logic       frame_err_out,         // Last frame had a low stop bit
    output logic       overrun_out            // A received byte was lost
);

    localparam int TW = CNT_W + 1;

    typedef struct packed {
        // Input synchroniser and filtered line level
        logic             sync1;
        logic             sync2;
        logic             sync3;
        logic             line;
        // Rate detection
        abs_pkg::abs_rd_t rd;
        logic [CNT_W-1:0] m_full;
        logic [2:0]       m_six;
        logic             locked;
        logic [CNT_W-1:0] full;
        logic [CNT_W-1:0] half;
        // Transmitter
        abs_pkg::abs_tx_t tx;
        logic [TW-1:0]    tx_tmr;
        logic [7:0]       tx_sh;
        logic [2:0]       tx_bit;
        logic             tx_two;
        logic             tx_line;
        logic             tx_busy;
        logic             tx_rdy;
        // Receiver
        abs_pkg::abs_rx_t rx;
        logic [TW-1:0]    rx_tmr;
        logic [7:0]       rx_sh;
        logic [2:0]       rx_bit;
        logic             hold_valid;
        logic [7:0]       hold_data;
        logic             frame_err;
        logic             overrun;
    } abs_st_t;

    abs_st_t    st_r;
    abs_st_t    st_nxt;
    logic       agree;
    logic       fall;
    logic       rise;
    logic       hold_take;
    logic       fifo_ready;
    logic       tx_take;
    logic       tx_tick;
    logic       rx_tick;
    logic [TW-1:0] full_w;
    logic [TW-1:0] half_w;

    // Filtered line edges: a change counts when the last two stages agree
    assign agree     = (st_r.sync2 == st_r.sync3);
    assign fall      = agree && !st_r.sync3 && st_r.line;
    assign rise      = agree && st_r.sync3 && !st_r.line;

    // Timer and handshake terms
    assign full_w    = TW'(st_r.full);
    assign half_w    = TW'(st_r.half);
    assign tx_tick   = (st_r.tx_tmr == TW'(1));
    assign rx_tick   = (st_r.rx_tmr == TW'(1));
    assign tx_take   = tx_valid_in && st_r.tx_rdy;            // see R20
    assign hold_take = st_r.hold_valid && fifo_ready;

    // Outputs straight from the state register
    assign serial_out_line_out = st_r.tx_line;
    assign rate_locked_out     = st_r.locked;
    assign tx_ready_out        = st_r.tx_rdy;
    assign tx_busy_out         = st_r.tx_busy;
    assign frame_err_out       = st_r.frame_err;
    assign overrun_out         = st_r.overrun;

    // Next state of synchroniser, rate detection, transmitter and receiver
    always_comb begin
        st_nxt = st_r;

        // Three-stage synchroniser on the serial input
        st_nxt.sync1 = serial_in_line_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        if (agree) begin
            st_nxt.line = st_r.sync3;
        end

        // Byte handed to the FIFO frees the holding register
        if (hold_take) begin
            st_nxt.hold_valid = 1'b0;
        end

        // Rate detection: measure the low run of a space character
        case (st_r.rd)
            abs_pkg::ABS_RD_ARM: begin
                if (agree && st_r.sync3) begin
                    st_nxt.rd = abs_pkg::ABS_RD_WAIT;            // see R9
                end
            end
            abs_pkg::ABS_RD_WAIT: begin
                if (fall) begin
                    st_nxt.m_full = '0;
                    st_nxt.m_six  = 3'h1;   // The rise cycle is never counted
                    st_nxt.rd     = abs_pkg::ABS_RD_MEAS;
                end
            end
            abs_pkg::ABS_RD_MEAS: begin
                if (rise) begin
                    st_nxt.full   = st_r.m_full;                // see R11
                    st_nxt.half   = st_r.m_full >> 1;           // see R11
                    st_nxt.rx_tmr = TW'(st_r.m_full);
                    st_nxt.rx_bit = '0;
                    if (st_r.m_full < CNT_W'(abs_pkg::ABS_MIN_FULL)) begin
                        st_nxt.rd = abs_pkg::ABS_RD_ARM;
                    end else begin
                        st_nxt.rd = abs_pkg::ABS_RD_SKIP;
                    end
                end else if (st_r.m_six == 3'(abs_pkg::ABS_SPACE_LOW_BITS - 1)) begin
                    // One count per six low cycles divides the run by six
                    st_nxt.m_six = '0;                          // see R19
                    if (st_r.m_full != '1) begin                // see R16
                        st_nxt.m_full = st_r.m_full + 1'b1;     // see R15
                    end
                end else begin
                    st_nxt.m_six = st_r.m_six + 1'b1;           // see R19
                end
            end
            abs_pkg::ABS_RD_SKIP: begin
                // Let the rest of the space pass up to mid stop bit
                if (rx_tick) begin
                    st_nxt.rx_bit = st_r.rx_bit + 1'b1;
                    if (st_r.rx_bit < 3'(abs_pkg::ABS_SKIP_BITS - 1)) begin
                        st_nxt.rx_tmr = full_w;
                    end else if (st_r.rx_bit == 3'(abs_pkg::ABS_SKIP_BITS - 1)) begin
                        st_nxt.rx_tmr = half_w;
                    end else begin
                        st_nxt.locked = 1'b1;                   // see R14
                        st_nxt.rd     = abs_pkg::ABS_RD_LOCK;
                    end
                end else begin
                    st_nxt.rx_tmr = st_r.rx_tmr - 1'b1;
                end
            end
            abs_pkg::ABS_RD_LOCK: begin
                st_nxt.rd = abs_pkg::ABS_RD_LOCK;
            end
            default: begin
                st_nxt.rd = abs_pkg::ABS_RD_ARM;
            end
        endcase

        // Transmitter: start, eight data bits, one or two stop bits
        case (st_r.tx)
            abs_pkg::ABS_TX_IDLE: begin
                st_nxt.tx_line = abs_pkg::ABS_LINE_IDLE;        // see R4
                if (tx_take) begin
                    st_nxt.tx_sh   = tx_data_in;
                    st_nxt.tx_line = 1'b0;                      // see R2
                    st_nxt.tx_tmr  = full_w;                    // see R12
                    st_nxt.tx_two  = two_stop_in;               // see R3
                    st_nxt.tx_bit  = '0;
                    st_nxt.tx_busy = 1'b1;                      // see R20
                    st_nxt.tx      = abs_pkg::ABS_TX_START;
                end
            end
            abs_pkg::ABS_TX_START: begin
                if (tx_tick) begin
                    st_nxt.tx_line = st_r.tx_sh[0];             // see R2
                    st_nxt.tx_sh   = st_r.tx_sh >> 1;
                    st_nxt.tx_tmr  = full_w;                    // see R8
                    st_nxt.tx      = abs_pkg::ABS_TX_DATA;
                end else begin
                    st_nxt.tx_tmr = st_r.tx_tmr - 1'b1;
                end
            end
            abs_pkg::ABS_TX_DATA: begin
                if (tx_tick) begin
                    st_nxt.tx_tmr = full_w;                     // see R12
                    if (st_r.tx_bit == 3'(abs_pkg::ABS_DATA_BITS - 1)) begin
                        st_nxt.tx_line = abs_pkg::ABS_LINE_IDLE; // see R2
                        st_nxt.tx_bit  = '0;
                        st_nxt.tx      = abs_pkg::ABS_TX_STOP;
                    end else begin
                        st_nxt.tx_line = st_r.tx_sh[0];
                        st_nxt.tx_sh   = st_r.tx_sh >> 1;
                        st_nxt.tx_bit  = st_r.tx_bit + 1'b1;
                    end
                end else begin
                    st_nxt.tx_tmr = st_r.tx_tmr - 1'b1;
                end
            end
            abs_pkg::ABS_TX_STOP: begin
                if (tx_tick) begin
                    if (st_r.tx_two && st_r.tx_bit
                            < 3'(abs_pkg::ABS_STOP_BITS_TTY - 1)) begin
                        st_nxt.tx_bit = st_r.tx_bit + 1'b1;     // see R3
                        st_nxt.tx_tmr = full_w;                 // see R1
                    end else begin
                        st_nxt.tx_busy = 1'b0;                  // see R20
                        st_nxt.tx      = abs_pkg::ABS_TX_IDLE;
                    end
                end else begin
                    st_nxt.tx_tmr = st_r.tx_tmr - 1'b1;
                end
            end
            default: begin
                st_nxt.tx = abs_pkg::ABS_TX_IDLE;
            end
        endcase

        // Receiver: only runs once the bit periods are known
        case (st_r.rx)
            abs_pkg::ABS_RX_IDLE: begin
                if (st_r.locked && fall) begin
                    // Re-time from this frame's own start edge
                    st_nxt.rx_tmr = full_w + half_w;            // see R7 R18
                    st_nxt.rx_bit = '0;
                    st_nxt.rx     = abs_pkg::ABS_RX_DATA;
                end
            end
            abs_pkg::ABS_RX_DATA: begin
                if (rx_tick) begin
                    st_nxt.rx_sh  = {st_r.line, st_r.rx_sh[7:1]}; // see R5 R6
                    st_nxt.rx_tmr = full_w;                     // see R13
                    if (st_r.rx_bit == 3'(abs_pkg::ABS_DATA_BITS - 1)) begin
                        st_nxt.rx = abs_pkg::ABS_RX_STOP;
                    end else begin
                        st_nxt.rx_bit = st_r.rx_bit + 1'b1;
                    end
                end else begin
                    st_nxt.rx_tmr = st_r.rx_tmr - 1'b1;
                end
            end
            abs_pkg::ABS_RX_STOP: begin
                if (rx_tick) begin
                    st_nxt.frame_err = !st_r.line;              // see R2
                    if (st_r.hold_valid && !hold_take) begin
                        st_nxt.overrun = 1'b1;
                    end else begin
                        st_nxt.hold_valid = 1'b1;               // see R13
                        st_nxt.hold_data  = st_r.rx_sh;
                    end
                    st_nxt.rx = abs_pkg::ABS_RX_IDLE;
                end else begin
                    st_nxt.rx_tmr = st_r.rx_tmr - 1'b1;
                end
            end
            default: begin
                st_nxt.rx = abs_pkg::ABS_RX_IDLE;
            end
        endcase

        // A new measurement drops the old rate and any frame being received
        if (rate_detect_req_in) begin
            st_nxt.locked  = 1'b0;                              // see R9 R17
            st_nxt.overrun = st_nxt.overrun && !st_r.overrun; // Clears a set flag even on a fresh loss; a fresh loss sets a clear one
            st_nxt.rx      = abs_pkg::ABS_RX_IDLE;
            st_nxt.rd      = abs_pkg::ABS_RD_ARM;
        end

        // Ready for a new byte only when idle at a measured rate
        st_nxt.tx_rdy = st_nxt.locked && (st_nxt.tx == abs_pkg::ABS_TX_IDLE);
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_r         <= '0;
            st_r.tx_line <= abs_pkg::ABS_LINE_IDLE;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // Received bytes wait here until the reader takes them
    abs_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clock_in     (clock_in),
        .rst_n_in     (rst_n_in),
        .clk_en_in    (clk_en_in),
        .wr_data_in   (st_r.hold_data),
        .wr_valid_in  (st_r.hold_valid),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (rx_data_out),
        .rd_valid_out (rx_valid_out),
        .rd_ready_in  (rx_ready_in)
    );

endmodule : abs_serial_console

// File: testbench/abs_serial_console_checker.sv
`timescale 1ns/100ps
module abs_serial_console_checker (
    input wire logic       clock_in,            // Clock
    input wire logic       rst_n_in,            // Reset
    input wire logic       clk_en_in,           // Enable
    input wire logic       serial_in_line_in,   // Line in
    input wire logic       serial_out_line_out, // Line out
    input wire logic       rate_detect_req_in,  // Rearm
    input wire logic       rate_locked_out,     // Locked
    input wire logic       two_stop_in,         // Two stops
    input wire logic [7:0] tx_data_in,          // Tx byte
    input wire logic       tx_valid_in,         // Tx offer
    input wire logic       tx_ready_out,        // Tx take
    input wire logic       tx_busy_out,         // Tx busy
    input wire logic [7:0] rx_data_out,         // Rx byte
    input wire logic       rx_valid_out,        // Rx present
    input wire logic       rx_ready_in,         // Rx take
    input wire logic       frame_err_out,       // Bad stop
    input wire logic       overrun_out          // Byte lost
);
    logic [15:0] low_run_r; // Current low run on the input line
    logic [15:0] max_low_r; // Longest low run since rearm

    // Track the longest low run, a lock needs at least six short bits
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || rate_detect_req_in) begin
            low_run_r <= 16'h0000;
            max_low_r <= 16'h0000;
        end else if (clk_en_in) begin
            low_run_r <= serial_in_line_in ? 16'h0000 : low_run_r + 16'h0001;
            max_low_r <= (low_run_r > max_low_r) ? low_run_r : max_low_r;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in || !clk_en_in);

    // Line and transmit handshake
    AST_IDLE_MARK: assert property (!tx_busy_out |-> serial_out_line_out)
        else $error("line low outside a frame");
    AST_START_BIT: assert property (tx_valid_in && tx_ready_out
        |=> !serial_out_line_out && tx_busy_out && !tx_ready_out) else $error("no start bit");
    AST_BUSY_NO_READY: assert property (tx_busy_out |-> !tx_ready_out)
        else $error("ready while busy");
    AST_READY_LOCKED: assert property (tx_ready_out |-> rate_locked_out)
        else $error("ready before lock");
    AST_FRAME_MIN: assert property ($rose(tx_busy_out) |-> tx_busy_out [*8])
        else $error("frame too short");
    AST_LAST_STOP: assert property ($fell(tx_busy_out)
        |-> $past(serial_out_line_out) && serial_out_line_out) else $error("stop bit low");
    // Rate detection
    AST_REARM: assert property (rate_detect_req_in |=> !rate_locked_out)
        else $error("lock kept after rearm");
    AST_SPACE_RUN: assert property ($rose(rate_locked_out) |-> max_low_r >= 16'h000c)
        else $error("lock without a low run");
    // Receive side
    AST_RX_STEADY: assert property (rx_valid_out && !rx_ready_in && !rate_detect_req_in
        |=> rx_valid_out && $stable(rx_data_out)) else $error("rx byte changed");
    AST_LOST_STICKY: assert property (overrun_out && !rate_detect_req_in |=> overrun_out)
        else $error("overrun dropped");

    CV_TX_TWO: cover property (tx_valid_in && tx_ready_out && two_stop_in);
    CV_RX_TAKE: cover property (rx_valid_out && rx_ready_in);
    CV_LOST: cover property ($rose(overrun_out));
endmodule : abs_serial_console_checker

bind abs_serial_console abs_serial_console_checker abs_serial_console_checker_i (.*);

// File: testbench/abs_term_model.sv
`timescale 1ns/100ps
module abs_term_model (
    input  wire logic clock_in, // System clock
    input  wire logic line_in,  // Line from the device
    output logic      line_out  // Line to the device
);
    int         period = 48; // Bit period in clocks
    logic [7:0] got_q[$];    // Bytes decoded from the device

    initial line_out = 1'b1; // Line rests at mark

    // Send one frame and one idle bit, stop level chosen by the caller
    task automatic send(input logic [7:0] b, input logic stop_lvl);
        logic [10:0] f;
        f = {1'b1, stop_lvl, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (period) @(posedge clock_in);
        end
    endtask : send

    // Decode device frames at mid-bit, keep those with a high stop bit
    always begin
        logic [7:0] d;
        @(negedge line_in);
        repeat (period / 2) @(posedge clock_in);
        for (int i = 0; i < 8; i++) begin
            repeat (period) @(posedge clock_in);
            d[i] = line_in;
        end
        repeat (period) @(posedge clock_in);
        if (line_in) got_q.push_back(d);
    end
endmodule : abs_term_model

// File: testbench/tb_abs_serial_console.sv
`timescale 1ns/100ps
module tb_abs_serial_console;
    logic       clock_in           = 1'b0;  // Clock
    logic       rst_n_in           = 1'b0;  // Reset
    logic       clk_en_in          = 1'b1;  // Enable
    logic       serial_in_line_in;          // Line in
    logic       serial_out_line_out;        // Line out
    logic       rate_detect_req_in = 1'b0;  // Rearm
    logic       rate_locked_out;            // Locked
    logic       two_stop_in        = 1'b0;  // Two stops
    logic [7:0] tx_data_in         = 8'h00; // Tx byte
    logic       tx_valid_in        = 1'b0;  // Tx offer
    logic       tx_ready_out;               // Tx take
    logic       tx_busy_out;                // Tx busy
    logic [7:0] rx_data_out;                // Rx byte
    logic       rx_valid_out;               // Rx present
    logic       rx_ready_in        = 1'b0;  // Rx take
    logic       frame_err_out;              // Bad stop
    logic       overrun_out;                // Byte lost
    int         fails              = 0;     // Mismatches
    int         num_checks         = 0;     // Comparisons

    always #12.5 clock_in = ~clock_in;

    abs_serial_console abs_serial_console_i (.*);
    abs_term_model abs_term_model_i (
        .clock_in (clock_in),
        .line_in  (serial_out_line_out),
        .line_out (serial_in_line_in)
    );

    task automatic end_sim();
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // A wait that ran out counts as a mismatch
    task automatic hung();
        chk_val(32'h0, 32'h1);
        end_sim();
    endtask : hung

    // Idle line, no lock, no offer after reset
    task automatic t_reset();
        chk_val(serial_out_line_out, 1'b1);
        chk_val(rate_locked_out, 1'b0);
        chk_val(tx_ready_out, 1'b0);
    endtask : t_reset

    // Measure the rate from a space sent at period p
    task automatic t_detect(input int p);
        int n;
        abs_term_model_i.period = p;
        repeat (8) @(posedge clock_in);
        abs_term_model_i.send(8'h20, 1'b1);
        for (n = 0; n < 4 * p && rate_locked_out !== 1'b1; n++) @(posedge clock_in);
        if (n == 4 * p) hung();
        repeat (2) @(posedge clock_in);
        chk_val(rate_locked_out, 1'b1);
        chk_val(rx_valid_out, 1'b0);
        chk_val(tx_ready_out, 1'b1);
    endtask : t_detect

    // Send a byte, keep offering another for the first bit period of the frame, time the frame
    task automatic t_tx(input logic [7:0] b, input logic two, input int p);
        int n;
        int busy;
        @(posedge clock_in);
        tx_data_in  <= b;
        two_stop_in <= two;
        tx_valid_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (tx_ready_out !== 1'b1 && n < 100);
        if (n == 100) hung();
        tx_data_in <= ~b;
        busy = 0;
        for (n = 0; n < 12 * p; n++) begin
            @(posedge clock_in);
            if (n == p) tx_valid_in <= 1'b0;
            if (tx_busy_out === 1'b1) busy++;
        end
        chk_val(busy, (two ? 11 : 10) * p);
        chk_val(abs_term_model_i.got_q.size(), 1);
        chk_val(abs_term_model_i.got_q.pop_front(), b);
    endtask : t_tx

    // Receive a byte after an odd gap, check the frame error flag, take it
    task automatic t_rx(input logic [7:0] b, input logic stop_lvl);
        int n;
        repeat (7) @(posedge clock_in);
        abs_term_model_i.send(b, stop_lvl);
        for (n = 0; n < 100 && rx_valid_out !== 1'b1; n++) @(posedge clock_in);
        if (n == 100) hung();
        chk_val(rx_data_out, b);
        chk_val(frame_err_out, !stop_lvl);
        rx_ready_in <= 1'b1;
        @(posedge clock_in);
        rx_ready_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk_val(rx_valid_out, 1'b0);
    endtask : t_rx

    // Fill the receive path with no reader until a byte is lost, then drain
    task automatic t_fill();
        int n;
        for (int i = 0; i < 12; i++) abs_term_model_i.send(8'h40 + i[7:0], 1'b1);
        chk_val(overrun_out, 1'b1);
        for (n = 0; n < 12 && rx_valid_out === 1'b1; n++) begin
            chk_val(rx_data_out, 8'h40 + n[7:0]);
            rx_ready_in <= 1'b1;
            @(posedge clock_in);
            rx_ready_in <= 1'b0;
            repeat (3) @(posedge clock_in);
        end
        chk_val(n, abs_pkg::ABS_FIFO_DEPTH + 2);
    endtask : t_fill

    // Rearm, measure another rate, then run both directions at it
    task automatic t_redetect(input int p);
        rate_detect_req_in <= 1'b1;
        @(posedge clock_in);
        rate_detect_req_in <= 1'b0;
        @(posedge clock_in);
        chk_val(rate_locked_out, 1'b0);
        chk_val(overrun_out, 1'b0);
        t_detect(p);
        t_tx(8'hc6, 1'b0, p);
        t_rx(8'h39, 1'b1);
    endtask : t_redetect

    // Cut a hang short
    initial begin
        #1250000;
        hung();
    end

    initial begin
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        t_reset();
        t_detect(48);
        t_tx(8'ha5, 1'b0, 48);
        t_tx(8'h01, 1'b1, 48);
        t_rx(8'h5a, 1'b1);
        t_rx(8'hff, 1'b0);
        t_rx(8'h00, 1'b1);
        t_fill();
        t_redetect(30);
        end_sim();
    end
endmodule : tb_abs_serial_console
